/* File: src/adc_status_pkg.sv */
package adc_status_pkg;

  // ****************************************************************
  // Status bit positions and constants.
  // ****************************************************************
  localparam int unsigned CAL_DONE_BIT  = 15;
  localparam int unsigned AUX_ERR_BIT   = 13;
  localparam int unsigned CUR_ERR_BIT   = 12;
  localparam int unsigned CONT_EVT_BIT  = 5;
  localparam int unsigned CMP_HIT_BIT   = 4;
  localparam int unsigned TEMP_RDY_BIT  = 2;
  localparam int unsigned VOLT_RDY_BIT  = 1;
  localparam int unsigned CUR_RDY_BIT   = 0;
  localparam int unsigned STATUS_WIDTH  = 16;
  localparam int unsigned DATA_WIDTH    = 16;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] STATUS_USED   = 16'hB037;
  localparam logic [15:0] POS_FULL      = 16'h7FFF;
  localparam logic [15:0] NEG_FULL      = 16'h8000;

  // One conversion arriving from the decimation path.
  typedef struct packed {
    logic        valid;
    logic        over;
    logic        under;
    logic [15:0] data;
  } conv_t;

  // Register access strobes from the core bus.
  typedef struct packed {
    logic modeWrite;
    logic filterWrite;
    logic curCtrlWrite;
    logic curResultRead;
    logic auxResultRead;
  } access_t;

endpackage

/* File: src/adc_status_flag_logic.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Calibration completion sets status bit 15.
// - Writes to mode, filter or current control clear bit 15.
// - Auxiliary channel over or under range sets bit 13.
// - Valid in-range voltage result written clears bit 13.
// - Current channel over or under range sets bit 12.
// - Valid in-range current result written clears bit 12.
// - Range errors store result clamped to negative or positive full scale.
// - Continuous mode sets bit 5 after every current conversion.
// - Reading current result clears bits 5 and 0.
// - Comparator enabled: bit 4 set when absolute current exceeds threshold.
// - Reconfiguring the converter clears bit 4.
// - Temperature enabled: valid temperature result written sets bit 2.
// - Voltage enabled: valid voltage result written sets bit 1.
// - Current enabled: valid current result written sets bit 0.
// - Calibration completion also sets bits 2, 1 and 0.
// - Reading either result register clears bits 2 and 1.
// - Low eight status bits, masked, OR into one interrupt request.
// - Results not overwritten until ready bits clear, unless core powered down.
// - Status register is read only and resets to zero.
module adc_status_flag_logic
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     clkEn,
  input  wire logic                     calDone,
  input  wire adc_status_pkg::conv_t    curConv,
  input  wire adc_status_pkg::conv_t    auxConv,
  input  wire logic                     auxIsTemp,
  input  wire logic                     curEnable,
  input  wire logic                     voltEnable,
  input  wire logic                     tempEnable,
  input  wire logic                     contEnable,
  input  wire logic                     cmpEnable,
  input  wire logic [15:0]              curThreshold,
  input  wire logic                     corePowerDown,
  input  wire logic [7:0]               irqMask,
  input  wire adc_status_pkg::access_t  access,
  output logic [15:0]                   adc_status_flags,
  output logic [15:0]                   curResult,
  output logic [15:0]                   auxResult,
  output logic                          adcIrq
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [15:0] clampResult(input adc_status_pkg::conv_t c);
    logic [15:0] r;
    r = c.data;
    if (c.under)
      r = adc_status_pkg::NEG_FULL;
    else if (c.over)
      r = adc_status_pkg::POS_FULL;
    return r;
  endfunction

  function automatic logic [15:0] absValue(input logic [15:0] v);
    return v[15] ? 16'((~v) + 16'h0001) : v;
  endfunction

  // ****************************************************************
  // Event decode.
  // ****************************************************************
  logic [15:0] statusReg;
  logic [15:0] statusNext;
  logic [15:0] curResultReg;
  logic [15:0] auxResultReg;
  logic        irqReg;

  wire reconfig   = access.modeWrite | access.filterWrite | access.curCtrlWrite;
  wire curRange   = curConv.valid & (curConv.over | curConv.under);
  wire auxRange   = auxConv.valid & (auxConv.over | auxConv.under);
  wire curRdyFree = ~statusReg[adc_status_pkg::CUR_RDY_BIT];
  wire auxRdyFree = ~(statusReg[adc_status_pkg::VOLT_RDY_BIT]
                    | statusReg[adc_status_pkg::TEMP_RDY_BIT]);
  wire curWrite   = curConv.valid & (curRdyFree | corePowerDown);
  wire auxWrite   = auxConv.valid & (auxRdyFree | corePowerDown);
  wire [15:0] curStored = clampResult(curConv);
  wire [15:0] auxStored = clampResult(auxConv);
  wire curOk      = curWrite & ~curRange;
  wire voltOk     = auxWrite & ~auxRange & ~auxIsTemp;
  wire tempOk     = auxWrite & ~auxRange & auxIsTemp;
  wire cmpHit     = cmpEnable & curConv.valid & (absValue(curStored) > curThreshold);
  wire anyRead    = access.curResultRead | access.auxResultRead;

  // Sets are applied after clears so an event in a clearing cycle is kept.
  always_comb
  begin
    statusNext = statusReg;
    if (reconfig)
    begin
      statusNext[adc_status_pkg::CAL_DONE_BIT] = 1'b0;
      statusNext[adc_status_pkg::CMP_HIT_BIT]  = 1'b0;
    end
    if (voltOk)
      statusNext[adc_status_pkg::AUX_ERR_BIT] = 1'b0;
    if (curOk)
      statusNext[adc_status_pkg::CUR_ERR_BIT] = 1'b0;
    if (access.curResultRead)
    begin
      statusNext[adc_status_pkg::CONT_EVT_BIT] = 1'b0;
      statusNext[adc_status_pkg::CUR_RDY_BIT]  = 1'b0;
    end
    if (anyRead)
    begin
      statusNext[adc_status_pkg::TEMP_RDY_BIT] = 1'b0;
      statusNext[adc_status_pkg::VOLT_RDY_BIT] = 1'b0;
    end
    if (calDone)
    begin
      statusNext[adc_status_pkg::CAL_DONE_BIT] = 1'b1;
      statusNext[adc_status_pkg::TEMP_RDY_BIT] = 1'b1;
      statusNext[adc_status_pkg::VOLT_RDY_BIT] = 1'b1;
      statusNext[adc_status_pkg::CUR_RDY_BIT]  = 1'b1;
    end
    if (auxRange)
      statusNext[adc_status_pkg::AUX_ERR_BIT] = 1'b1;
    if (curRange)
      statusNext[adc_status_pkg::CUR_ERR_BIT] = 1'b1;
    if (contEnable & curConv.valid)
      statusNext[adc_status_pkg::CONT_EVT_BIT] = 1'b1;
    if (cmpHit)
      statusNext[adc_status_pkg::CMP_HIT_BIT] = 1'b1;
    if (tempEnable & tempOk)
      statusNext[adc_status_pkg::TEMP_RDY_BIT] = 1'b1;
    if (voltEnable & voltOk)
      statusNext[adc_status_pkg::VOLT_RDY_BIT] = 1'b1;
    if (curEnable & curOk)
      statusNext[adc_status_pkg::CUR_RDY_BIT] = 1'b1;
    statusNext = statusNext & adc_status_pkg::STATUS_USED;
  end

  wire irqNext = |(statusNext[7:0] & irqMask);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      statusReg    <= adc_status_pkg::STATUS_RESET;
      curResultReg <= 16'h0000;
      auxResultReg <= 16'h0000;
      irqReg       <= 1'b0;
    end
    else if (clkEn)
    begin
      statusReg <= statusNext;
      irqReg    <= irqNext;
      if (curWrite)
        curResultReg <= curStored;
      if (auxWrite)
        auxResultReg <= auxStored;
    end
  end

  assign adc_status_flags = statusReg;
  assign curResult        = curResultReg;
  assign auxResult        = auxResultReg;
  assign adcIrq           = irqReg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  // Named views of the flags keep the properties short.
  wire        calFlag    = statusReg[adc_status_pkg::CAL_DONE_BIT];
  wire        auxErrFlag = statusReg[adc_status_pkg::AUX_ERR_BIT];
  wire        curErrFlag = statusReg[adc_status_pkg::CUR_ERR_BIT];
  wire        contFlag   = statusReg[adc_status_pkg::CONT_EVT_BIT];
  wire        cmpFlag    = statusReg[adc_status_pkg::CMP_HIT_BIT];
  wire        tempRdy    = statusReg[adc_status_pkg::TEMP_RDY_BIT];
  wire        voltRdy    = statusReg[adc_status_pkg::VOLT_RDY_BIT];
  wire        curRdy     = statusReg[adc_status_pkg::CUR_RDY_BIT];
  wire [15:0] rsvdBits   = statusReg & ~adc_status_pkg::STATUS_USED;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  freeze_hold_a: assert property (!clkEn
    |=> $stable(statusReg) && $stable(adcIrq)
        && $stable(curResultReg) && $stable(auxResultReg))
    else $error("state changed while the clock enable was low");

  cal_set_a: assert property (clkEn && calDone
    |=> calFlag)
    else $error("calibration did not set its flag");

  cal_ready_a: assert property (clkEn && calDone
    |=> tempRdy && voltRdy && curRdy)
    else $error("calibration did not set the ready flags");

  cal_clear_a: assert property (clkEn && reconfig && !calDone
    |=> !calFlag)
    else $error("reconfiguration did not clear the calibration flag");

  aux_err_a: assert property (clkEn && auxRange
    |=> auxErrFlag)
    else $error("auxiliary range error not flagged");

  aux_err_clr_a: assert property (clkEn && voltOk
    |=> !auxErrFlag)
    else $error("auxiliary range error not cleared");

  cur_err_a: assert property (clkEn && curRange
    |=> curErrFlag)
    else $error("current range error not flagged");

  cur_err_clr_a: assert property (clkEn && curOk
    |=> !curErrFlag)
    else $error("current range error not cleared");

  clamp_under_a: assert property (clkEn && curWrite && curConv.under
    |=> curResultReg == adc_status_pkg::NEG_FULL)
    else $error("current underrange not clamped");

  clamp_over_a: assert property (clkEn && curWrite && curConv.over && !curConv.under
    |=> curResultReg == adc_status_pkg::POS_FULL)
    else $error("current overrange not clamped");

  aux_clamp_a: assert property (clkEn && auxWrite && auxConv.under
    |=> auxResultReg == adc_status_pkg::NEG_FULL)
    else $error("auxiliary underrange not clamped");

  cont_evt_a: assert property (clkEn && contEnable && curConv.valid
    |=> contFlag)
    else $error("continuous event missing");

  cont_quiet_a: assert property (clkEn && !contEnable && !contFlag
    |=> !contFlag)
    else $error("continuous event set while disabled");

  cur_read_a: assert property (clkEn && access.curResultRead
    && !curConv.valid && !auxConv.valid && !calDone
    |=> !curRdy && !contFlag && !voltRdy && !tempRdy)
    else $error("current read did not clear ready flags");

  cmp_hit_a: assert property (clkEn && cmpHit
    |=> cmpFlag)
    else $error("comparator flag missing");

  cmp_quiet_a: assert property (clkEn && !cmpEnable && !cmpFlag
    |=> !cmpFlag)
    else $error("comparator flag set while disabled");

  cmp_clear_a: assert property (clkEn && reconfig && !cmpHit
    |=> !cmpFlag)
    else $error("reconfiguration did not clear the comparator flag");

  temp_rdy_a: assert property (clkEn && tempEnable && tempOk
    |=> tempRdy)
    else $error("temperature ready flag missing");

  volt_rdy_a: assert property (clkEn && voltEnable && voltOk
    |=> voltRdy)
    else $error("voltage ready flag missing");

  cur_rdy_a: assert property (clkEn && curEnable && curOk
    |=> curRdy)
    else $error("current ready flag missing");

  aux_read_a: assert property (clkEn && access.auxResultRead
    && !auxConv.valid && !calDone
    |=> !tempRdy && !voltRdy)
    else $error("auxiliary read did not clear ready flags");

  hold_res_a: assert property (clkEn && curRdy && !corePowerDown
    |=> $stable(curResultReg))
    else $error("current result overwritten while ready");

  aux_hold_a: assert property (clkEn && (voltRdy || tempRdy) && !corePowerDown
    |=> $stable(auxResultReg))
    else $error("auxiliary result overwritten while ready");

  pd_write_a: assert property (clkEn && corePowerDown && curConv.valid
    |=> curResultReg == $past(curStored))
    else $error("current result not written during power down");

  irq_or_a: assert property (clkEn
    |=> adcIrq == |(statusReg[7:0] & $past(irqMask)))
    else $error("interrupt does not follow masked flags");

  reset_zero_a: assert property (disable iff (1'b0) !rst_n
    |=> statusReg == adc_status_pkg::STATUS_RESET && !adcIrq)
    else $error("reset did not clear the status");

  rsvd_zero_a: assert property (rsvdBits == 16'h0000)
    else $error("reserved status bit set");

  // ****************************************************************
  // Coverage.
  // ****************************************************************
  cal_seen_c: cover property (clkEn && calDone);
  cmp_seen_c: cover property (clkEn && cmpHit);
  block_seen_c: cover property (clkEn && curConv.valid && !curWrite);
  pd_seen_c: cover property (clkEn && corePowerDown && auxConv.valid && !auxRdyFree);
  irq_seen_c: cover property (adcIrq);

endmodule

`default_nettype wire

/* File: sim/test_adc_status_flag_logic.sv */
`timescale 1ns/1ps
`default_nettype none

module test_adc_status_flag_logic;
  logic                    clk, rst_n, clkEn, corePowerDown, calDone, auxIsTemp, adcIrq;
  logic                    curEnable, voltEnable, tempEnable, contEnable, cmpEnable;
  logic [7:0]              irqMask;
  logic [15:0]             curThreshold, status, curResult, auxResult;
  adc_status_pkg::conv_t   curConv, auxConv;
  adc_status_pkg::access_t access;
  int                      miscompares, compares, cycles;

  adc_status_flag_logic u_dut (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .calDone(calDone),
    .curConv(curConv), .auxConv(auxConv), .auxIsTemp(auxIsTemp),
    .curEnable(curEnable), .voltEnable(voltEnable), .tempEnable(tempEnable),
    .contEnable(contEnable), .cmpEnable(cmpEnable), .curThreshold(curThreshold),
    .corePowerDown(corePowerDown), .irqMask(irqMask), .access(access),
    .adc_status_flags(status), .curResult(curResult), .auxResult(auxResult),
    .adcIrq(adcIrq));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conv(input logic aux, input logic [1:0] ou, input logic [15:0] d);
    adc_status_pkg::conv_t c;
    c = {1'b1, ou, d};
    if (aux) auxConv = c;
    else curConv = c;
    step;
    curConv = '0;
    auxConv = '0;
  endtask

  task automatic acc(input logic [4:0] a);
    access = a;
    step;
    access = '0;
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic calibration;
    for (int i = 0; i < 3; i++)
    begin
      calDone = 1'b1;
      step;
      calDone = 1'b0;
      chk(status, 16'h8007);
      acc(5'h10 >> i);
      chk(status, 16'h0007);
    end
    acc(5'h02);
    chk(status, 16'h0000);
  endtask

  task automatic current_path;
    curEnable = 1'b1;
    contEnable = 1'b1;
    irqMask = 8'h01;
    conv(1'b0, 2'b00, 16'h0123);
    chk(curResult, 16'h0123);
    chk(status, 16'h0021);
    step;
    chkBit(adcIrq, 1'b1);
    irqMask = 8'h00;
    step;
    chkBit(adcIrq, 1'b0);
    conv(1'b0, 2'b00, 16'h0456);
    chk(curResult, 16'h0123);
    acc(5'h02);
    chk(status, 16'h0000);
    conv(1'b0, 2'b10, 16'h1111);
    chk(curResult, 16'h7FFF);
    chk(status & 16'hF000, 16'h1000);
    acc(5'h02);
    conv(1'b0, 2'b00, 16'h0010);
    chk(status & 16'hF000, 16'h0000);
    acc(5'h02);
    conv(1'b0, 2'b01, 16'h0010);
    chk(curResult, 16'h8000);
    acc(5'h02);
  endtask

  task automatic aux_path;
    voltEnable = 1'b1;
    tempEnable = 1'b1;
    conv(1'b1, 2'b00, 16'h0ABC);
    chk(auxResult, 16'h0ABC);
    chk(status & 16'h0007, 16'h0002);
    acc(5'h01);
    chk(status & 16'h0007, 16'h0000);
    auxIsTemp = 1'b1;
    conv(1'b1, 2'b01, 16'h0001);
    chk(auxResult, 16'h8000);
    chk(status & 16'h2000, 16'h2000);
    acc(5'h01);
    auxIsTemp = 1'b0;
    conv(1'b1, 2'b00, 16'h0200);
    chk(status & 16'h2000, 16'h0000);
    acc(5'h01);
    auxIsTemp = 1'b1;
    conv(1'b1, 2'b00, 16'h0300);
    chk(status & 16'h0007, 16'h0004);
    acc(5'h02);
    chk(status & 16'h0007, 16'h0000);
  endtask

  task automatic comparator;
    cmpEnable = 1'b1;
    curThreshold = 16'h0100;
    conv(1'b0, 2'b00, 16'h0100);
    chk(status & 16'h0010, 16'h0000);
    acc(5'h02);
    conv(1'b0, 2'b00, 16'hFE00);
    chk(status & 16'h0010, 16'h0010);
    acc(5'h08);
    chk(status & 16'h0010, 16'h0000);
  endtask

  task automatic hold_and_power;
    acc(5'h02);
    chk(status, 16'h0000);
    clkEn = 1'b0;
    calDone = 1'b1;
    conv(1'b0, 2'b00, 16'h0042);
    calDone = 1'b0;
    chk(status, 16'h0000);
    chk(curResult, 16'hFE00);
    clkEn = 1'b1;
    auxIsTemp = 1'b0;
    conv(1'b1, 2'b00, 16'h0111);
    chk(auxResult, 16'h0111);
    step;
    conv(1'b1, 2'b00, 16'h0222);
    chk(auxResult, 16'h0111);
    step;
    corePowerDown = 1'b1;
    conv(1'b1, 2'b00, 16'h0333);
    chk(auxResult, 16'h0333);
    step;
    conv(1'b0, 2'b00, 16'h0044);
    step;
    conv(1'b0, 2'b00, 16'h0055);
    chk(curResult, 16'h0055);
    corePowerDown = 1'b0;
    chk(status & 16'hF03F, 16'h0023);
    irqMask = 8'h21;
    step;
    chkBit(adcIrq, 1'b1);
    rst_n = 1'b0;
    step;
    chk(status, 16'h0000);
    chk(curResult, 16'h0000);
    chkBit(adcIrq, 1'b0);
    rst_n = 1'b1;
    calDone = 1'b1;
    step;
    calDone = 1'b0;
    chk(status, 16'h8007);
    chkBit(adcIrq, 1'b1);
  endtask

  // ****************************************************************
  // Clock, timeout and main sequence.
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end

  initial
  begin
    {rst_n, calDone, auxIsTemp, curEnable, voltEnable} = '0;
    {tempEnable, contEnable, cmpEnable, irqMask, curThreshold} = '0;
    {curConv, auxConv, access} = '0;
    clkEn = 1'b1;
    corePowerDown = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(status, 16'h0000);
    calibration;
    current_path;
    aux_path;
    comparator;
    hold_and_power;
    tally_and_finish;
  end
endmodule

`default_nettype wire
